// File: design/zcd_pkg.sv
package zcd_pkg;
	// Byte addresses of the register words
	localparam logic [7:0] ZCD_CONTROL_ADDR = 8'h00;
	localparam logic [7:0] ZCD_STATUS_ADDR = 8'h04;
	localparam logic [7:0] ZCD_MASK_ADDR = 8'h08;
	localparam logic [7:0] ZCD_SYSCFG_ADDR = 8'h0C;
	// Control register fields
	localparam int ZCD_SEN_BIT = 7;
	localparam int ZCD_LEVEL_BIT = 5;
	localparam int ZCD_INV_BIT = 4;
	localparam int ZCD_RISE_BIT = 1;
	localparam int ZCD_FALL_BIT = 0;
	localparam logic [7:0] ZCD_CONTROL_WMASK = 8'h93;
	localparam logic [7:0] ZCD_CONTROL_RESET = 8'h00;
	// Status / mask fields
	localparam int ZCD_FLAG_BIT = 0;
	// System config register fields
	localparam int ZCD_GIE_BIT = 0;
	localparam int ZCD_PRIORITY_SCHEME_ENABLE_BIT = 1;
	localparam int ZCD_PRIO_BIT = 2;
	localparam int ZCD_PMD_BIT = 3;
	localparam logic [3:0] ZCD_SYSCFG_RESET = 4'h0;
endpackage

// File: design/zcd_logic.sv
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module zcd_logic
	import zcd_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sinkActive,
	input wire logic bootDefaultOffConfig,
	input wire logic sleepMode,
	output logic stageEnable,
	output logic crossingLevelSignal,
	output logic crossingIrq,
	output logic crossingIrqHigh,
	output logic crossingIrqLow
);

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic syncA;
		logic syncB;
		logic levelPrev;
		logic primed;
		logic swEnable;
		logic invert;
		logic riseEnable;
		logic fallEnable;
		logic eventFlag;
		logic irqMask;
		logic [3:0] sysCfg;
		logic [31:0] rdata;
		logic cfgOff;
		logic cfgTaken;
	} zcd_state_t;

	zcd_state_t state_q;
	zcd_state_t state_d;
	logic level;
	logic riseEdge;
	logic fallEdge;
	logic edgeHit;
	logic access;
	logic wrEn;
	logic rdEn;
	logic [7:0] controlView;
	logic setup;
	logic statusRead;
	logic [31:0] readWord;

	////////////////////////////////////////////////////////////////////////
	// Level path; sleepMode deliberately gates nothing
	assign level = state_q.syncB ^ state_q.invert;
	assign riseEdge = state_q.primed & level & ~state_q.levelPrev;
	assign fallEdge = state_q.primed & ~level & state_q.levelPrev;
	assign edgeHit = (riseEdge & state_q.riseEnable)
		| (fallEdge & state_q.fallEnable);

	// Read data is captured at the setup edge so it stands in the access phase
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wrEn = access & pwrite;
	assign rdEn = access & ~pwrite;
	assign statusRead = rdEn & (paddr == ZCD_STATUS_ADDR);
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = state_q.rdata;

	always_comb begin
		controlView = 8'h00;
		controlView[ZCD_SEN_BIT] = state_q.swEnable;
		controlView[ZCD_LEVEL_BIT] = level;
		controlView[ZCD_INV_BIT] = state_q.invert;
		controlView[ZCD_RISE_BIT] = state_q.riseEnable;
		controlView[ZCD_FALL_BIT] = state_q.fallEnable;
	end

	always_comb begin
		readWord = 32'h0000_0000;
		unique case (paddr)
			ZCD_CONTROL_ADDR: readWord = {24'h00_0000, controlView};
			ZCD_STATUS_ADDR: readWord = {31'h0000_0000, state_q.eventFlag};
			ZCD_MASK_ADDR: readWord = {31'h0000_0000, state_q.irqMask};
			ZCD_SYSCFG_ADDR: readWord = {28'h000_0000, state_q.sysCfg};
			default: readWord = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_d = state_q;
		state_d.syncA = sinkActive;
		state_d.syncB = state_q.syncA;
		state_d.levelPrev = level;
		state_d.primed = 1'b1;
		if (!state_q.cfgTaken) begin
			state_d.cfgOff = bootDefaultOffConfig;
			state_d.cfgTaken = 1'b1;
		end
		if (wrEn) begin
			unique case (paddr)
				ZCD_CONTROL_ADDR: begin
					state_d.swEnable = pwdata[ZCD_SEN_BIT];
					state_d.invert = pwdata[ZCD_INV_BIT];
					state_d.riseEnable = pwdata[ZCD_RISE_BIT];
					state_d.fallEnable = pwdata[ZCD_FALL_BIT];
				end
				ZCD_MASK_ADDR: state_d.irqMask = pwdata[ZCD_FLAG_BIT];
				ZCD_SYSCFG_ADDR: state_d.sysCfg = pwdata[3:0];
				default: ;
			endcase
		end
		if (setup && !pwrite) begin
			state_d.rdata = readWord;
		end
		// Only a flag that was reported is cleared; a later set waits
		if (statusRead && state_q.rdata[ZCD_FLAG_BIT]) begin
			state_d.eventFlag = 1'b0;
		end
		if (edgeHit) begin
			state_d.eventFlag = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_q <= '0;
			state_q.sysCfg <= ZCD_SYSCFG_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		crossingLevelSignal = level;
		if (!state_q.cfgOff && !bootDefaultOffConfig) begin
			stageEnable = 1'b1;
		end else begin
			stageEnable = state_q.swEnable
				& ~state_q.sysCfg[ZCD_PMD_BIT];
		end
		crossingIrq = state_q.eventFlag & state_q.irqMask
			& state_q.sysCfg[ZCD_GIE_BIT];
		crossingIrqHigh = crossingIrq & (~state_q.sysCfg[ZCD_PRIORITY_SCHEME_ENABLE_BIT]
			| state_q.sysCfg[ZCD_PRIO_BIT]);
		crossingIrqLow = crossingIrq & state_q.sysCfg[ZCD_PRIORITY_SCHEME_ENABLE_BIT]
			& ~state_q.sysCfg[ZCD_PRIO_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	a_edge_sets_flag: assert property (@(posedge mclk) disable iff (sys_rst)
		edgeHit |=> state_q.eventFlag)
		else $error("enabled edge did not set flag");
	a_rise_needs_enable: assert property (@(posedge mclk) disable iff (sys_rst)
		!state_q.eventFlag && riseEdge && !fallEdge && !state_q.riseEnable
		|=> !state_q.eventFlag)
		else $error("rise edge set flag while disabled");
	a_edge_one_cycle: assert property (@(posedge mclk) disable iff (sys_rst)
		riseEdge |=> !riseEdge)
		else $error("rise pulse longer than one cycle");
	a_level_tracks_sync: assert property (@(posedge mclk) disable iff (sys_rst)
		crossingLevelSignal == (state_q.syncB ^ state_q.invert))
		else $error("level does not follow sink and invert");
	a_sync_two_stage: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(sinkActive) ##1 sinkActive |=> state_q.syncB)
		else $error("synchroniser latency wrong");
	a_irq_gated: assert property (@(posedge mclk) disable iff (sys_rst)
		crossingIrq |-> state_q.eventFlag && state_q.irqMask
		&& state_q.sysCfg[ZCD_GIE_BIT])
		else $error("interrupt without enables");
	a_prio_route: assert property (@(posedge mclk) disable iff (sys_rst)
		!(crossingIrqHigh && crossingIrqLow))
		else $error("both priorities asserted");
	a_pmd_disables: assert property (@(posedge mclk) disable iff (sys_rst)
		state_q.cfgOff && state_q.sysCfg[ZCD_PMD_BIT] |-> !stageEnable)
		else $error("power-off bit ignored");

	////////////////////////////////////////////////////////////////////////
	// Flag set and clear
	a_read_clears_flag: assert property (@(posedge mclk) disable iff (sys_rst)
		statusRead && state_q.rdata[ZCD_FLAG_BIT] && !edgeHit
		|=> !state_q.eventFlag)
		else $error("status read did not clear flag");

	a_flag_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
		state_q.eventFlag && !statusRead
		|=> state_q.eventFlag)
		else $error("flag dropped without a status read");

	a_rise_sets_flag: assert property (@(posedge mclk) disable iff (sys_rst)
		riseEdge && state_q.riseEnable
		|=> state_q.eventFlag)
		else $error("enabled rise edge did not set flag");

	a_fall_sets_flag: assert property (@(posedge mclk) disable iff (sys_rst)
		fallEdge && state_q.fallEnable
		|=> state_q.eventFlag)
		else $error("enabled fall edge did not set flag");

	a_fall_needs_enable: assert property (@(posedge mclk) disable iff (sys_rst)
		!state_q.eventFlag && fallEdge && !state_q.fallEnable
		|=> !state_q.eventFlag)
		else $error("fall edge set flag while disabled");

	a_status_capture: assert property (@(posedge mclk) disable iff (sys_rst)
		setup && !pwrite && paddr == ZCD_STATUS_ADDR
		|=> state_q.rdata[ZCD_FLAG_BIT] == $past(state_q.eventFlag))
		else $error("status read data wrong");

	////////////////////////////////////////////////////////////////////////
	// Level path and edge detectors
	a_sync_first: assert property (@(posedge mclk) disable iff (sys_rst)
		!$past(sys_rst)
		|-> state_q.syncA == $past(sinkActive))
		else $error("first sync stage wrong");

	a_sync_second: assert property (@(posedge mclk) disable iff (sys_rst)
		!$past(sys_rst)
		|-> state_q.syncB == $past(state_q.syncA))
		else $error("second sync stage wrong");

	a_level_prev: assert property (@(posedge mclk) disable iff (sys_rst)
		!$past(sys_rst)
		|-> state_q.levelPrev == $past(level))
		else $error("previous level not one cycle old");

	a_edge_exclusive: assert property (@(posedge mclk) disable iff (sys_rst)
		!(riseEdge && fallEdge))
		else $error("rise and fall in one cycle");

	a_invert_applies: assert property (@(posedge mclk) disable iff (sys_rst)
		$changed(state_q.invert) && $stable(state_q.syncB)
		|-> $changed(crossingLevelSignal))
		else $error("invert select did not flip level");

	a_fall_one_cycle: assert property (@(posedge mclk) disable iff (sys_rst)
		fallEdge |=> !fallEdge)
		else $error("fall pulse longer than one cycle");

	////////////////////////////////////////////////////////////////////////
	// Interrupt routing
	a_irq_complete: assert property (@(posedge mclk) disable iff (sys_rst)
		state_q.eventFlag && state_q.irqMask && state_q.sysCfg[ZCD_GIE_BIT]
		|-> crossingIrq)
		else $error("interrupt missing with all enables");

	a_mask_gates: assert property (@(posedge mclk) disable iff (sys_rst)
		!state_q.irqMask |-> !crossingIrq)
		else $error("interrupt while masked");

	a_high_route: assert property (@(posedge mclk) disable iff (sys_rst)
		crossingIrq
		&& (!state_q.sysCfg[ZCD_PRIORITY_SCHEME_ENABLE_BIT] || state_q.sysCfg[ZCD_PRIO_BIT])
		|-> crossingIrqHigh)
		else $error("high priority interrupt missing");

	a_low_route: assert property (@(posedge mclk) disable iff (sys_rst)
		crossingIrq
		&& state_q.sysCfg[ZCD_PRIORITY_SCHEME_ENABLE_BIT] && !state_q.sysCfg[ZCD_PRIO_BIT]
		|-> crossingIrqLow)
		else $error("low priority interrupt missing");

	////////////////////////////////////////////////////////////////////////
	// Enable gating and register bus
	a_pmd_ignored: assert property (@(posedge mclk) disable iff (sys_rst)
		state_q.cfgTaken && !state_q.cfgOff && !bootDefaultOffConfig
		|-> stageEnable)
		else $error("always-on detector was disabled");

	a_sw_gates_stage: assert property (@(posedge mclk) disable iff (sys_rst)
		state_q.cfgTaken && state_q.cfgOff && !state_q.swEnable
		|-> !stageEnable)
		else $error("stage enabled without software enable");

	a_sw_enables_stage: assert property (@(posedge mclk) disable iff (sys_rst)
		state_q.cfgTaken && state_q.cfgOff && state_q.swEnable
		&& !state_q.sysCfg[ZCD_PMD_BIT]
		|-> stageEnable)
		else $error("software enable ignored");

	a_control_zeros: assert property (@(posedge mclk) disable iff (sys_rst)
		setup && !pwrite && paddr == ZCD_CONTROL_ADDR
		|=> state_q.rdata[31:8] == 24'h00_0000 && !state_q.rdata[6]
		&& state_q.rdata[3:2] == 2'b00)
		else $error("unused control bits not zero");

	a_read_data_stands: assert property (@(posedge mclk) disable iff (sys_rst)
		!(setup && !pwrite)
		|=> $stable(prdata))
		else $error("read data changed outside setup");

endmodule
`default_nettype wire

// File: bench/zcd_stage_model.sv
`timescale 1ns/1ns
`default_nettype none
module zcd_stage_model (
	input wire logic mclk,
	input wire logic aboveRef,
	output logic sinkActive
);
	// Sinks while the pin sits above the reference, sources below it
	always_ff @(posedge mclk) begin
		sinkActive <= aboveRef;
	end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import zcd_pkg::*;
	logic mclk = 0;
	logic sysRst = 1;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic aboveRef = 0;
	logic bootCfg = 0;
	logic sleep = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic [7:0] rd;
	logic pready, sinkActive, level, irq, irqHi, irqLo, stageEn;
	int nErrors = 0;
	int nTests = 0;
	int cyc = 0;
	initial forever #50 mclk = ~mclk;
	zcd_logic i_dut (.mclk(mclk), .sys_rst(sysRst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(), .sinkActive(sinkActive),
		.bootDefaultOffConfig(bootCfg), .sleepMode(sleep), .stageEnable(stageEn),
		.crossingLevelSignal(level), .crossingIrq(irq),
		.crossingIrqHigh(irqHi), .crossingIrqLow(irqLo));
	zcd_stage_model i_stage (.mclk(mclk), .aboveRef(aboveRef),
		.sinkActive(sinkActive));
	////////////////////////////////////////////////////////////////////////
	task automatic stopTest;
		$display("errors %0d tests %0d", nErrors, nTests);
		if (nErrors == 0 && nTests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		nTests++;
		if (got !== exp) begin
			nErrors++;
			$display("[FAIL] %s exp %h got %h", what, exp, got);
		end
	endtask
	// Read data is taken at the edge where pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge mclk) penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata[7:0];
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 2000) begin
			nErrors++;
			stopTest();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge mclk);
		sysRst <= 1'b0;
		@(posedge mclk);
		apb(1'b0, ZCD_CONTROL_ADDR, 8'h00);
		chk("control", 8'h00, rd);
		chk("stage", 8'h01, {7'h00, stageEn});
		apb(1'b1, ZCD_MASK_ADDR, 8'h01);
		apb(1'b1, ZCD_SYSCFG_ADDR, 8'h01);
		apb(1'b1, ZCD_CONTROL_ADDR, 8'h02);
		aboveRef <= 1'b1;
		repeat (6) @(posedge mclk);
		chk("level", 8'h01, {7'h00, level});
		chk("irq", 8'h01, {7'h00, irq});
		chk("irqHigh", 8'h01, {7'h00, irqHi});
		apb(1'b0, ZCD_STATUS_ADDR, 8'h00);
		chk("flag", 8'h01, rd);
		apb(1'b0, ZCD_STATUS_ADDR, 8'h00);
		chk("cleared", 8'h00, rd);
		aboveRef <= 1'b0;
		repeat (6) @(posedge mclk);
		apb(1'b0, ZCD_STATUS_ADDR, 8'h00);
		chk("fall off", 8'h00, rd);
		apb(1'b1, ZCD_CONTROL_ADDR, 8'h12);
		repeat (2) @(posedge mclk);
		chk("inverted", 8'h01, {7'h00, level});
		apb(1'b0, ZCD_CONTROL_ADDR, 8'h00);
		chk("control inv", 8'h32, rd);
		apb(1'b1, ZCD_SYSCFG_ADDR, 8'h03);
		chk("irqLow", 8'h01, {7'h00, irqLo});
		apb(1'b0, ZCD_STATUS_ADDR, 8'h00);
		chk("toggle flag", 8'h01, rd);
		apb(1'b0, 8'h10, 8'h00);
		chk("unmapped", 8'h00, rd);
		sysRst <= 1'b1;
		bootCfg <= 1'b1;
		sleep <= 1'b1;
		aboveRef <= 1'b0;
		repeat (3) @(posedge mclk);
		sysRst <= 1'b0;
		@(posedge mclk);
		chk("stage off", 8'h00, {7'h00, stageEn});
		apb(1'b1, ZCD_CONTROL_ADDR, 8'h80);
		chk("stage sw", 8'h01, {7'h00, stageEn});
		aboveRef <= 1'b1;
		repeat (6) @(posedge mclk);
		chk("sleep level", 8'h01, {7'h00, level});
		apb(1'b0, ZCD_STATUS_ADDR, 8'h00);
		chk("rise off", 8'h00, rd);
		apb(1'b1, ZCD_SYSCFG_ADDR, 8'h08);
		chk("stage pmd", 8'h00, {7'h00, stageEn});
		stopTest();
	end
endmodule
`default_nettype wire
